// [hdl/kpsd_top.sv]
`timescale 1ns/1ps

// What this block does
// [RULE1] The debounce interval is a 6-bit count of 4 ms steps, with zero meaning 256 ms.
// [RULE2] Both presses and releases must hold for the debounce interval before being accepted.
// [RULE3] A 2-bit scan field sets the delay between checking keys, from 1 to 4 ms, code 01 being 1 ms.
// [RULE4] Code 10 is 2 ms, code 11 is 3 ms and code 00 is 4 ms.
// [RULE5] The control/status register shows the live keypad clock level when read.
// [RULE6] With auto scan enabled the block scans the matrix on its own.
// [RULE7] With auto scan disabled software drives and samples the matrix itself.
// [RULE8] In auto scan a debounced press sets the key-detect flag and raises the interrupt.
// [RULE9] In auto scan the pressed key's column and row are stored for software.
// [RULE10] In bypass a falling row edge after all rows were high sets the flag, with no debounce.
// [RULE11] Any read of the control/status register clears the key-detect flag; a read in the same cycle as a new detect leaves it set here.
// [RULE12] In bypass the row edge detector works with the keypad tick stopped.
// [RULE13] The flag reaches the interrupt output only while the interrupt enable bit is set.
// [RULE14] The flag is set even while the interrupt enable is clear.
module kpsd_top
#(
  parameter int ROWS = 4,                           // Row inputs
  parameter int COLS = 4,                           // Column drivers
  parameter int TICK_CYCLES = kpsd_pkg::TICK_CYCLES // Clocks per 1 ms tick
)
(
  input  wire logic            clk_i,       // 40 MHz clock
  input  wire logic            rst_i,       // Sync reset, active high
  input  wire logic            tick_run_i,  // Keypad 1 kHz clock enabled
  input  wire logic [7:0]      adr_i,       // Wishbone byte address
  input  wire logic [31:0]     dat_i,       // Wishbone write data
  input  wire logic [3:0]      sel_i,       // Wishbone byte select
  input  wire logic            we_i,        // Wishbone write enable
  input  wire logic            cyc_i,       // Wishbone cycle
  input  wire logic            stb_i,       // Wishbone strobe
  output logic [31:0]          dat_o,       // Wishbone read data
  output logic                 ack_o,       // Wishbone acknowledge
  output logic                 err_o,       // Wishbone error, unmapped
  input  wire logic [ROWS-1:0] row_i,       // Row lines, low when pressed
  output logic [COLS-1:0]      col_o,       // Column drive, low active
  output logic [COLS-1:0]      col_oe_o,    // Column output enables
  output logic                 irq_o,       // Key interrupt, active high
  output logic                 tick_level_o // Keypad clock level
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  initial
  begin
    if (ROWS < 1 || ROWS > 8 || COLS < 1 || COLS > 8 || TICK_CYCLES < 2)
      $error("kpsd_top: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  kpsd_pkg::kpsd_timing_t     timing;
  kpsd_pkg::kpsd_scan_state_t scan_state;
  logic        auto_scan_enable;
  logic        key_detect_flag;
  logic        key_detect_irq_enable;
  logic        keypad_clock_level;
  logic [31:0] tick_count;
  logic        tick;
  logic [2:0]  scan_ms;
  logic [2:0]  scan_limit;
  logic [2:0]  col_index;
  logic [7:0]  key_column;
  logic [7:0]  key_row;
  logic [ROWS-1:0] row_prev;
  logic        rows_all_high;
  logic        bypass_event;
  logic        press_seen;
  logic        raw_press;
  logic        db_stable;
  logic        db_rise;
  logic [7:0]  hit_col;
  logic [7:0]  hit_row;
  logic [7:0]  next_row_code;
  logic        access;
  logic        mapped;
  logic [5:0]  index;
  logic        status_read;

  assign access      = cyc_i && stb_i && !ack_o && !err_o;
  // Only six index bits reach the block, so the decode compares the low six
  // bits of each register index; the upper index bits are implied by the bus
  assign index       = adr_i[7:kpsd_pkg::ADDR_LSB];
  assign mapped      = index == kpsd_pkg::IDX_TIMING_CONFIG[5:0] || index == kpsd_pkg::IDX_CONTROL_STATUS[5:0]
                    || index == kpsd_pkg::IDX_KEY_COLUMN[5:0] || index == kpsd_pkg::IDX_KEY_ROW[5:0];
  assign status_read = access && !we_i && index == kpsd_pkg::IDX_CONTROL_STATUS[5:0];

  // ----------------------------------------------------------------
  // Keypad 1 kHz clock
  // ----------------------------------------------------------------
  // Tick stops with the clock; level toggles each half period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !tick_run_i)
    begin
      tick_count         <= 32'h0000_0000;
      tick               <= 1'b0;
      keypad_clock_level <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (tick_count == 32'(TICK_CYCLES - 1))
      begin
        tick_count <= 32'h0000_0000;
        tick       <= 1'b1;
      end
      else
        tick_count <= tick_count + 32'h0000_0001;
      if (tick_count == 32'(TICK_CYCLES / 2 - 1) || tick_count == 32'(TICK_CYCLES - 1))
        keypad_clock_level <= !keypad_clock_level;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tick_level_o <= 1'b0;
    else
      tick_level_o <= keypad_clock_level;
  end

  // ----------------------------------------------------------------
  // Scan interval decode
  // ----------------------------------------------------------------
  // Code 00 wraps to the longest delay
  assign scan_limit = (timing.scan_interval == 2'h0) ? 3'(kpsd_pkg::SCT_MAX_MS)
                                                     : {1'b0, timing.scan_interval}; // [RULE3] [RULE4]

  // ----------------------------------------------------------------
  // Column scanner
  // ----------------------------------------------------------------
  // Parks on a pressed column so the debouncer sees a steady level
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !auto_scan_enable)
    begin
      scan_state <= kpsd_pkg::SCAN_DRIVE;
      col_index  <= 3'h0;
      scan_ms    <= 3'h0;
    end
    else
    begin
      case (scan_state)
        kpsd_pkg::SCAN_DRIVE:
        begin
          scan_ms    <= 3'h0;
          scan_state <= kpsd_pkg::SCAN_SETTLE; // [RULE6]
        end
        kpsd_pkg::SCAN_SETTLE:
        begin
          if (tick)
          begin
            if (scan_ms + 3'h1 >= scan_limit)
              scan_state <= kpsd_pkg::SCAN_CHECK;
            else
              scan_ms <= scan_ms + 3'h1;
          end
        end
        kpsd_pkg::SCAN_CHECK:
        begin
          if (!press_seen && !db_stable)
          begin
            col_index <= (col_index == 3'(COLS - 1)) ? 3'h0 : col_index + 3'h1;
            scan_state <= kpsd_pkg::SCAN_DRIVE;
          end
        end
        default:
          scan_state <= kpsd_pkg::SCAN_DRIVE;
      endcase
    end
  end

  // Drive one column low at a time; bypass leaves the lines to software
  generate
    for (genvar c = 0; c < COLS; c++)
    begin : g_col
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          col_o[c]    <= 1'b1;
          col_oe_o[c] <= 1'b0;
        end
        else
        begin
          col_o[c]    <= !(auto_scan_enable && col_index == 3'(c));
          col_oe_o[c] <= auto_scan_enable; // [RULE7]
        end
      end
    end
  endgenerate

  assign press_seen = row_i != {ROWS{1'b1}};
  assign raw_press  = (scan_state == kpsd_pkg::SCAN_CHECK) && press_seen;

  // Row code: first low row in the driven column
  always_comb
  begin
    next_row_code = 8'h00;
    for (int r = ROWS - 1; r >= 0; r--)
      if (!row_i[r])
        next_row_code = 8'(r);
  end

  kpsd_debounce u_debounce
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i || !auto_scan_enable),
    .tick_i   (tick),
    .raw_i    (raw_press),
    .steps_i  (timing.debounce_interval),
    .stable_o (db_stable),
    .rise_o   (db_rise)
  );

  // Capture location when the press is accepted
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      key_column <= 8'h00;
      key_row    <= 8'h00;
      hit_col    <= 8'h00;
      hit_row    <= 8'h00;
    end
    else
    begin
      if (raw_press)
      begin
        hit_col <= {5'h00, col_index};
        hit_row <= next_row_code;
      end
      if (db_rise)
      begin
        key_column <= hit_col; // [RULE9]
        key_row    <= hit_row;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bypass row edge detect
  // ----------------------------------------------------------------
  // Runs on the system clock, not the keypad tick, so it works with the tick stopped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      row_prev <= {ROWS{1'b1}};
    else
      row_prev <= row_i; // [RULE12]
  end

  assign rows_all_high = row_prev == {ROWS{1'b1}};
  assign bypass_event  = !auto_scan_enable && rows_all_high && press_seen; // [RULE10]

  // ----------------------------------------------------------------
  // Key-detect flag and interrupt
  // ----------------------------------------------------------------
  // Set wins over the read clear so no event is lost
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      key_detect_flag <= 1'b0;
    else if ((auto_scan_enable && db_rise) || bypass_event) // [RULE8] [RULE14]
      key_detect_flag <= 1'b1;
    else if (status_read)
      key_detect_flag <= 1'b0; // [RULE11]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= key_detect_flag && key_detect_irq_enable; // [RULE13]
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Writes to control bits; the flag and clock level are read-only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timing                <= kpsd_pkg::kpsd_timing_t'(kpsd_pkg::RST_TIMING_CONFIG);
      auto_scan_enable      <= kpsd_pkg::RST_CONTROL_STATUS[kpsd_pkg::BIT_AUTO_SCAN];
      key_detect_irq_enable <= kpsd_pkg::RST_CONTROL_STATUS[kpsd_pkg::BIT_IRQ_ENABLE];
    end
    else if (access && we_i && sel_i[0])
    begin
      if (index == kpsd_pkg::IDX_TIMING_CONFIG[5:0])
        timing <= kpsd_pkg::kpsd_timing_t'(dat_i[7:0]);
      if (index == kpsd_pkg::IDX_CONTROL_STATUS[5:0])
      begin
        auto_scan_enable      <= dat_i[kpsd_pkg::BIT_AUTO_SCAN];
        key_detect_irq_enable <= dat_i[kpsd_pkg::BIT_IRQ_ENABLE];
      end
    end
  end

  // One-cycle answer; live clock level sampled on the read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= access && mapped;
      err_o <= access && !mapped;
      dat_o <= 32'h0000_0000;
      if (access && !we_i)
      begin
        case (index)
          kpsd_pkg::IDX_TIMING_CONFIG[5:0]:  dat_o[7:0] <= timing;
          kpsd_pkg::IDX_CONTROL_STATUS[5:0]:
          begin
            dat_o[kpsd_pkg::BIT_CLK_LEVEL]  <= keypad_clock_level; // [RULE5]
            dat_o[kpsd_pkg::BIT_AUTO_SCAN]  <= auto_scan_enable;
            dat_o[kpsd_pkg::BIT_DETECT]     <= key_detect_flag;
            dat_o[kpsd_pkg::BIT_IRQ_ENABLE] <= key_detect_irq_enable;
          end
          kpsd_pkg::IDX_KEY_COLUMN[5:0]:     dat_o[7:0] <= key_column;
          kpsd_pkg::IDX_KEY_ROW[5:0]:        dat_o[7:0] <= key_row;
          default:                      dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : kpsd_top

// [hdl/kpsd_pkg.sv]
package kpsd_pkg;

  // ----------------------------------------------------------------
  // Register map: byte address is index*4, low six index bits decoded
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TIMING_CONFIG  = 8'hD3;
  localparam logic [7:0] IDX_CONTROL_STATUS = 8'hD4;
  localparam logic [7:0] IDX_KEY_COLUMN     = 8'hD5;
  localparam logic [7:0] IDX_KEY_ROW        = 8'hD6;
  localparam int         ADDR_LSB           = 2;

  localparam logic [7:0] RST_TIMING_CONFIG  = 8'h00;
  localparam logic [7:0] RST_CONTROL_STATUS = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DBT_LSB        = 2;
  localparam int DBT_MSB        = 7;
  localparam int SCT_LSB        = 0;
  localparam int SCT_MSB        = 1;
  localparam int BIT_CLK_LEVEL  = 3;
  localparam int BIT_AUTO_SCAN  = 2;
  localparam int BIT_DETECT     = 1;
  localparam int BIT_IRQ_ENABLE = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int TICK_HZ       = 1_000;
  localparam int TICK_CYCLES   = CLK_HZ / TICK_HZ;
  localparam int DBT_STEP_MS   = 4;
  localparam int DBT_MAX_STEPS = 64;
  localparam int SCT_MAX_MS    = 4;

  // ----------------------------------------------------------------
  // Carried types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] debounce_interval;
    logic [1:0] scan_interval;
  } kpsd_timing_t;

  typedef enum logic [1:0] {
    SCAN_DRIVE  = 2'b00,
    SCAN_SETTLE = 2'b01,
    SCAN_CHECK  = 2'b10
  } kpsd_scan_state_t;

endpackage : kpsd_pkg

// [hdl/kpsd_debounce.sv]
`timescale 1ns/1ps

// Holds a state until a new level stays stable for a whole interval
module kpsd_debounce
(
  input  wire logic       clk_i,     // System clock
  input  wire logic       rst_i,     // Sync reset, active high
  input  wire logic       tick_i,    // 1 ms tick
  input  wire logic       raw_i,     // Raw key-present level
  input  wire logic [5:0] steps_i,   // Interval in 4 ms steps, 0 = 64
  output logic            stable_o,  // Debounced level
  output logic            rise_o     // Pulse on accepted press
);

  localparam logic [8:0] ONE_MS = 9'h001;

  // Nine bits: the longest interval is 256 ms, which overflows a byte
  logic [8:0] elapsed;
  logic [8:0] limit;

  // Zero code stands for the longest interval
  assign limit = (steps_i == 6'h00) ? 9'(kpsd_pkg::DBT_MAX_STEPS * kpsd_pkg::DBT_STEP_MS)
                                    : 9'({3'h0, steps_i} * kpsd_pkg::DBT_STEP_MS); // [RULE1]

  // Both presses and releases must hold for the interval
  always_ff @(posedge clk_i)
  begin
    rise_o <= 1'b0;
    if (rst_i)
    begin
      stable_o <= 1'b0;
      elapsed  <= 9'h000;
    end
    else if (raw_i == stable_o)
      elapsed <= 9'h000;
    else if (tick_i)
    begin
      if (elapsed + ONE_MS >= limit)
      begin
        stable_o <= raw_i; // [RULE2]
        rise_o   <= raw_i;
        elapsed  <= 9'h000;
      end
      else
        elapsed <= elapsed + ONE_MS;
    end
  end

endmodule : kpsd_debounce

// [bench/kpsd_chk.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port relations of the keypad block
// ----------------------------------------------------------------
module kpsd_chk
#(
  parameter int ROWS = 4, // Row inputs
  parameter int COLS = 4  // Column drivers
)
(
  input wire logic            clk_i,       // Clock
  input wire logic            rst_i,       // Sync reset
  input wire logic            tick_run_i,  // Tick enable
  input wire logic [7:0]      adr_i,       // Address
  input wire logic [31:0]     dat_i,       // Write data
  input wire logic [3:0]      sel_i,       // Byte select
  input wire logic            we_i,        // Write enable
  input wire logic            cyc_i,       // Cycle
  input wire logic            stb_i,       // Strobe
  input wire logic [31:0]     dat_o,       // Read data
  input wire logic            ack_o,       // Acknowledge
  input wire logic            err_o,       // Error
  input wire logic [ROWS-1:0] row_i,       // Rows
  input wire logic [COLS-1:0] col_o,       // Columns
  input wire logic [COLS-1:0] col_oe_o,    // Column enables
  input wire logic            irq_o,       // Interrupt
  input wire logic            tick_level_o // Clock level
);
  logic req;
  logic hit;

  // Request that the slave is about to take, and whether it decodes
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign hit = adr_i[7:2] inside {kpsd_pkg::IDX_TIMING_CONFIG[5:0], kpsd_pkg::IDX_CONTROL_STATUS[5:0],
                                  kpsd_pkg::IDX_KEY_COLUMN[5:0], kpsd_pkg::IDX_KEY_ROW[5:0]};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_mapped_ack: assert property (req && hit |=> ack_o && !err_o) else $error("mapped access not acknowledged");
  a_unmapped_err: assert property (req && !hit |=> err_o && !ack_o) else $error("unmapped access not refused");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_err_pulse: assert property (err_o |=> !err_o) else $error("err held too long");
  a_upper_zero: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0) else $error("read upper bits set");
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && col_oe_o == '0 && !ack_o && !err_o && !tick_level_o)
    else $error("outputs not idle after reset");
  a_one_column: assert property ($onehot0(col_oe_o & ~col_o)) else $error("several columns driven");
  a_irq_cleared: assert property ($fell(irq_o) |-> $past(cyc_i && stb_i) || $past(cyc_i && stb_i, 2))
    else $error("interrupt dropped without access");
  a_level_frozen: assert property (!tick_run_i [*4] |-> $stable(tick_level_o))
    else $error("clock level moves while stopped");

  // Main scenarios
  c_write: cover property (ack_o && we_i);
  c_refused: cover property (err_o);
  c_irq: cover property ($rose(irq_o));
endmodule : kpsd_chk

// [bench/kpsd_keypad.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Switch matrix with one key under test
// ----------------------------------------------------------------
module kpsd_keypad
#(
  parameter int ROWS = 4, // Row lines
  parameter int COLS = 4  // Column lines
)
(
  input  wire logic            press_i,    // Key held down
  input  wire logic [7:0]      key_row_i,  // Key row position
  input  wire logic [7:0]      key_col_i,  // Key column position
  input  wire logic            sw_drive_i, // Software pulls columns low
  input  wire logic [COLS-1:0] col_i,      // Column levels
  input  wire logic [COLS-1:0] col_oe_i,   // Column enables
  output logic      [ROWS-1:0] row_o       // Row levels
);
  // Rows have pull-ups, so an open key never leaves a stale low
  always_comb
  begin
    row_o = '1;
    if (press_i && ((col_oe_i[key_col_i] && !col_i[key_col_i]) || sw_drive_i))
      row_o[key_row_i] = 1'b0;
  end
endmodule : kpsd_keypad

// [bench/tb.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Register-level tests of the keypad block
// ----------------------------------------------------------------
module tb;
  localparam int         TCK   = 4;
  localparam logic [7:0] A_TIM = {kpsd_pkg::IDX_TIMING_CONFIG[5:0], 2'b00};
  localparam logic [7:0] A_STA = {kpsd_pkg::IDX_CONTROL_STATUS[5:0], 2'b00};
  localparam logic [7:0] A_COL = {kpsd_pkg::IDX_KEY_COLUMN[5:0], 2'b00};
  localparam logic [7:0] A_ROW = {kpsd_pkg::IDX_KEY_ROW[5:0], 2'b00};
  logic        clk_i = 0, rst_i = 1, tick_run_i = 0, we_i = 0, cyc_i = 0, stb_i = 0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_o;
  logic        ack_o, err_o, irq_o, tick_level_o, press = 0, sw_drive = 1, e;
  logic [3:0]  row_i, col_o, col_oe_o;
  logic [7:0]  q;
  logic [7:0]  key_row = 8'h02, key_col = 8'h01;
  logic        lv;
  logic [7:0]  cfg [4] = '{8'h05, 8'h00, 8'hFE, 8'h0B};
  int          n_errors = 0, total_checks = 0, n, lim;

  always #12.5 clk_i = ~clk_i;

  kpsd_top #(.ROWS(4), .COLS(4), .TICK_CYCLES(TCK)) dut (.clk_i(clk_i), .rst_i(rst_i), .tick_run_i(tick_run_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .row_i(row_i), .col_o(col_o), .col_oe_o(col_oe_o), .irq_o(irq_o),
    .tick_level_o(tick_level_o));
  kpsd_keypad #(.ROWS(4), .COLS(4)) u_pad (.press_i(press), .key_row_i(key_row), .key_col_i(key_col),
    .sw_drive_i(sw_drive), .col_i(col_o), .col_oe_i(col_oe_o), .row_o(row_i));

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
      n_errors++;
    end
  endtask : check

  // One classic cycle; held until ack or err is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] r,
                      output logic er);
    int k;
    @(posedge clk_i);
    adr_i <= a; we_i <= w; dat_i <= {24'h0, d}; sel_i <= 4'h1; cyc_i <= 1'b1; stb_i <= 1'b1;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 50);
    r = dat_o[7:0];
    er = err_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    if (k >= 50) check(32'h0, 32'h1);
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    xfer(a, 1'b0, 8'h00, q, e);
    check(q & m, x);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d, q, e);
  endtask : wr

  task automatic wait_irq(input int l);
    n = 0;
    while (irq_o !== 1'b1 && n < l) begin @(posedge clk_i); n++; end
  endtask : wait_irq

  task automatic conclude;
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // Hang guard, far beyond the longest debounce in the table
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_TIM, 8'hFF, kpsd_pkg::RST_TIMING_CONFIG);
    rd(A_STA, 8'hFF, kpsd_pkg::RST_CONTROL_STATUS);
    xfer(8'h00, 1'b0, 8'h00, q, e);
    check(e, 1'b1);
    // Bypass with the tick stopped
    wr(A_STA, 8'h01);
    @(posedge clk_i) press <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(irq_o, 1'b1);
    rd(A_STA, 8'hFF, 8'h03);
    rd(A_STA, 8'hFF, 8'h01);
    check(irq_o, 1'b0);
    @(posedge clk_i) press <= 1'b0;
    wr(A_STA, 8'h00);
    @(posedge clk_i) press <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(irq_o, 1'b0);
    rd(A_STA, 8'hFF, 8'h02);
    @(posedge clk_i)
    begin
      press <= 1'b0; sw_drive <= 1'b0; tick_run_i <= 1'b1;
    end
    // Automatic scan over every scan code and debounce boundaries
    wr(A_STA, 8'h05);
    rd(A_STA, 8'hF7, 8'h05);
    // Running keypad clock toggles every half tick period
    lv = tick_level_o;
    n = 0;
    for (int j = 0; j < 16; j++)
    begin
      @(posedge clk_i);
      if (tick_level_o !== lv)
        n++;
      lv = tick_level_o;
    end
    check(n, 16 / (TCK / 2));
    // Key moves to a new row and column on every pass
    for (int i = 0; i < 4; i++)
    begin
      wr(A_TIM, cfg[i]);
      rd(A_TIM, 8'hFF, cfg[i]);
      lim = ((cfg[i][7:2] == 6'h00) ? 64 : int'(cfg[i][7:2])) * 4 * TCK;
      @(posedge clk_i)
      begin
        key_row <= 8'(i);
        key_col <= 8'(3 - i);
        press   <= 1'b1;
      end
      wait_irq(lim + 400);
      check(n >= lim, 1'b1);
      check(irq_o, 1'b1);
      rd(A_COL, 8'hFF, 8'(3 - i));
      rd(A_ROW, 8'hFF, 8'(i));
      rd(A_STA, 8'hF7, 8'h07);
      rd(A_STA, 8'hF7, 8'h05);
      @(posedge clk_i) press <= 1'b0;
      repeat (lim + 400) @(posedge clk_i);
    end
    // A release shorter than the interval must not be accepted
    wr(A_TIM, 8'h05);
    @(posedge clk_i) press <= 1'b1;
    wait_irq(500);
    rd(A_STA, 8'hF7, 8'h07);
    @(posedge clk_i) press <= 1'b0;
    repeat (12) @(posedge clk_i);
    press <= 1'b1;
    repeat (200) @(posedge clk_i);
    rd(A_STA, 8'hF7, 8'h05);
    conclude();
  end
endmodule : tb

bind kpsd_top kpsd_chk #(.ROWS(ROWS), .COLS(COLS)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .tick_run_i(tick_run_i),
  .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
  .ack_o(ack_o), .err_o(err_o), .row_i(row_i), .col_o(col_o), .col_oe_o(col_oe_o), .irq_o(irq_o),
  .tick_level_o(tick_level_o));
